// >>> verilog/port_pin_function_mux.v
// pin function multiplexer for port a bits 6/7, port b and port d
// Behaviour
// RL1: port a bit 6 is port bit or packet-commit input, per interface config field.
// RL2: asserted packet-commit commits fifo packet; polarity from polarity register bit 5.
// RL3: port a bit 7 is port bit, flag four or chip select, per config bits.
// RL4: as flag pin, port a bit 7 drives the programmable fifo status flag.
// RL5: deasserted fifo chip select makes all other fifo strobes ignored.
// RL6: port b is port bits or low data bus byte, per interface config field.
// RL7: port d is high data byte only with data bus mode and word-wide set.
// RL8: in nand usage port b is the bidirectional nand data bus.
// RL9: in nand usage port d drives active-low chip enables; two to seven may be gpio.
// RL10: after reset all pins are port bits, inputs, drivers disabled.
`timescale 1ns/1ps
`include "port_pin_mux_defines.vh"
module port_pin_function_mux
(
  // clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // configuration
  input wire [1:0] i_interface_config_field,
  input wire [7:0] i_port_a_config_reg,
  input wire [7:0] i_fifo_pin_polarity_reg,
  input wire i_endpoint_wordwide,
  input wire i_nand_mode,
  input wire [7:2] i_nand_ce_as_gpio,
  // port bit values and directions from the port registers
  input wire i_port_a_bit6_out,
  input wire i_port_a_bit6_oe,
  input wire i_port_a_bit7_out,
  input wire i_port_a_bit7_oe,
  input wire [7:0] i_port_b_out,
  input wire [7:0] i_port_b_oe,
  input wire [7:0] i_port_d_out,
  input wire [7:0] i_port_d_oe,
  // core side fifo / waveform engine / nand data
  input wire i_fifo_status_flag_four,
  input wire i_fifo_strobe_req,
  input wire [15:0] i_fifo_data_bus_out,
  input wire i_fifo_data_bus_oe,
  input wire [7:0] i_nand_data_out,
  input wire i_nand_data_oe,
  input wire [7:0] i_nand_chip_enable_n,
  // pins
  input wire i_pin_a6,
  input wire i_pin_a7,
  input wire [7:0] i_pin_b,
  input wire [7:0] i_pin_d,
  output reg o_pin_a6,
  output reg o_pin_a6_oe,
  output reg o_pin_a7,
  output reg o_pin_a7_oe,
  output reg [7:0] o_pin_b,
  output reg [7:0] o_pin_b_oe,
  output reg [7:0] o_pin_d,
  output reg [7:0] o_pin_d_oe,
  // synchronised results to core
  output reg o_port_a_bit6_in,
  output reg o_port_a_bit7_in,
  output reg [7:0] o_port_b_in,
  output reg [7:0] o_port_d_in,
  output reg [15:0] o_fifo_data_bus_in,
  output reg [7:0] o_nand_data_in,
  output reg o_packet_commit,
  output reg o_fifo_strobe_gated,
  output reg o_fifo_chip_selected
);
  wire [1:0] a_sync;
  wire [7:0] b_sync;
  wire [7:0] d_sync;
  reg pkt_prev;
  reg [1:0] cfg;

  function is_bus_mode;
    input [1:0] ifc;
    begin
      is_bus_mode = (ifc == `IFC_WAVEFORM) || (ifc == `IFC_SLAVE_FIFO);
    end
  endfunction

  pin_sync #(.WIDTH(2)) u_sync_a
  (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_pin_a7, i_pin_a6}),
    .o_sync(a_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_b
  (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_pin_b),
    .o_sync(b_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_d
  (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_pin_d),
    .o_sync(d_sync)
  );

  wire slave = (cfg == `IFC_SLAVE_FIFO) && !i_nand_mode;
  wire bus = is_bus_mode(cfg) && !i_nand_mode;
  wire hi_bus = bus && i_endpoint_wordwide; // see RL7
  wire a7_flag = slave && i_port_a_config_reg[`PORTA_CFG_FLAG_BIT];
  wire a7_cs = slave && !i_port_a_config_reg[`PORTA_CFG_FLAG_BIT];
  // chip select active low; absent pin means always selected
  wire cs_ok = a7_cs ? !a_sync[1] : 1'b1;
  wire pkt_level = a_sync[0] ~^ i_fifo_pin_polarity_reg[`POL_PACKET_COMMIT_IN_BIT]; // see RL2
  reg [7:0] d_val;
  reg [7:0] d_en;
  reg [7:0] b_val;
  reg [7:0] b_en;
  reg a7_val;
  reg a7_en;
  integer j;

  // port d source: nand chip enables, high data byte or port bits
  always @*
  begin
    d_val = i_port_d_out;
    d_en = i_port_d_oe;
    if (i_nand_mode)
    begin
      // enables zero and one have no port bit alternative
      d_val[1:0] = i_nand_chip_enable_n[1:0]; // see RL9
      d_en[1:0] = 2'b11;
      for (j = 2; j < 8; j = j + 1)
        if (!i_nand_ce_as_gpio[j])
        begin
          d_val[j] = i_nand_chip_enable_n[j]; // see RL9
          d_en[j] = 1'b1;
        end
    end
    else if (hi_bus)
    begin
      d_val = i_fifo_data_bus_out[15:8];
      d_en = {8{i_fifo_data_bus_oe}};
    end
  end

  // port b source: nand bus, low data byte or port bits
  always @*
  begin
    b_val = i_port_b_out;
    b_en = i_port_b_oe;
    if (i_nand_mode)
    begin
      b_val = i_nand_data_out; // see RL8
      b_en = {8{i_nand_data_oe}};
    end
    else if (bus)
    begin
      b_val = i_fifo_data_bus_out[7:0]; // see RL6
      b_en = {8{i_fifo_data_bus_oe}};
    end
  end

  // port a bit 7 source: flag output, select input or port bit
  always @*
  begin
    a7_val = i_port_a_bit7_out;
    a7_en = i_port_a_bit7_oe;
    if (a7_flag)
    begin
      a7_val = i_fifo_status_flag_four; // see RL4
      a7_en = 1'b1;
    end
    else if (a7_cs)
      a7_en = 1'b0; // see RL3
  end

  always @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      cfg <= `RESET_IFC; // see RL10
      pkt_prev <= 1'b0;
      o_pin_a6 <= 1'b0;
      o_pin_a6_oe <= 1'b0;
      o_pin_a7 <= 1'b0;
      o_pin_a7_oe <= 1'b0;
      o_pin_b <= `RESET_BYTE;
      o_pin_b_oe <= `RESET_BYTE;
      o_pin_d <= `RESET_BYTE;
      o_pin_d_oe <= `RESET_BYTE;
      o_port_a_bit6_in <= 1'b0;
      o_port_a_bit7_in <= 1'b0;
      o_port_b_in <= `RESET_BYTE;
      o_port_d_in <= `RESET_BYTE;
      o_fifo_data_bus_in <= 16'h0000;
      o_nand_data_in <= `RESET_BYTE;
      o_packet_commit <= 1'b0;
      o_fifo_strobe_gated <= 1'b0;
      o_fifo_chip_selected <= 1'b0;
    end
    else
    begin
      cfg <= i_interface_config_field;
      // port a bit 6
      o_pin_a6 <= i_port_a_bit6_out;
      o_pin_a6_oe <= slave ? 1'b0 : i_port_a_bit6_oe; // see RL1
      o_port_a_bit6_in <= a_sync[0];
      // tracks the pin in every mode: no false edge on entering slave mode
      pkt_prev <= pkt_level;
      o_packet_commit <= slave && pkt_level && !pkt_prev && cs_ok; // see RL2
      // port a bit 7
      o_pin_a7 <= a7_val;
      o_pin_a7_oe <= a7_en;
      o_port_a_bit7_in <= a_sync[1];
      o_fifo_chip_selected <= slave && cs_ok;
      o_fifo_strobe_gated <= slave && cs_ok && i_fifo_strobe_req; // see RL5
      // port b
      o_pin_b <= b_val;
      o_pin_b_oe <= b_en;
      o_port_b_in <= b_sync;
      o_nand_data_in <= b_sync;
      o_fifo_data_bus_in <= {hi_bus ? d_sync : 8'h00, b_sync};
      // port d
      o_pin_d <= d_val;
      o_pin_d_oe <= d_en;
      o_port_d_in <= d_sync;
    end
  end
endmodule

// >>> verilog/port_pin_mux_defines.vh
// constants for the port a/b/d pin function multiplexer
`ifndef PORT_PIN_MUX_DEFINES_VH
`define PORT_PIN_MUX_DEFINES_VH
`define IFC_PORTS 2'h0
`define IFC_RESERVED 2'h1
`define IFC_WAVEFORM 2'h2
`define IFC_SLAVE_FIFO 2'h3
`define POL_PACKET_COMMIT_IN_BIT 5
`define PORTA_CFG_FLAG_BIT 7
`define WORDWIDE_BIT 0
`define SYNC_DEPTH 3
`define RESET_IFC 2'h0
`define RESET_BYTE 8'h00
`endif

// >>> verilog/pin_sync.v
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
#(
  parameter WIDTH = 8
)
(
  input wire i_mclk,
  input wire i_sys_rst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer k;
  always @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      // a change counts once stages two and three agree
      for (k = 0; k < WIDTH; k = k + 1)
        if (stage2[k] == stage3[k])
          o_sync[k] <= stage3[k];
    end
  end
endmodule

// >>> verification/port_pin_mux_monitor.sv
// assertions on the pin function multiplexer ports
`timescale 1ns/1ps
module port_pin_mux_monitor
(
  // clock, reset, configuration
  input wire i_mclk,
  input wire i_sys_rst,
  input wire [1:0] i_interface_config_field,
  input wire [7:0] i_port_a_config_reg,
  input wire i_endpoint_wordwide,
  input wire i_nand_mode,
  input wire [7:2] i_nand_ce_as_gpio,
  // observed outputs
  input wire o_pin_a6_oe,
  input wire o_pin_a7_oe,
  input wire [7:0] o_pin_b_oe,
  input wire [7:0] o_pin_d_oe,
  input wire [15:0] o_fifo_data_bus_in,
  input wire o_packet_commit,
  input wire o_fifo_strobe_gated,
  input wire o_fifo_chip_selected
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  wire sl = i_interface_config_field == 2'h3 && !i_nand_mode;
  wire fl = sl && i_port_a_config_reg[7];
  a_idle_after_reset: assert property ($fell(i_sys_rst) |-> !{o_pin_a6_oe, o_pin_a7_oe, o_pin_b_oe, o_pin_d_oe})
    else $error("driver on after reset");
  a_a6_commit_in: assert property (sl[*3] |-> !o_pin_a6_oe) else $error("a6 driven in fifo mode");
  a_a7_select_in: assert property ((sl && !fl)[*3] |-> !o_pin_a7_oe) else $error("a7 driven as select");
  a_a7_flag_out: assert property (fl[*3] |-> o_pin_a7_oe) else $error("flag pin not driven");
  a_high_byte_zero: assert property ((!i_endpoint_wordwide)[*4] |-> o_fifo_data_bus_in[15:8] == 8'h00)
    else $error("high byte without word mode");
  a_nand_enables: assert property ((i_nand_mode && i_nand_ce_as_gpio == 6'h00)[*3] |-> o_pin_d_oe == 8'hff)
    else $error("chip enables not driven");
  a_commit_pulse: assert property (o_packet_commit |=> !o_packet_commit) else $error("long commit");
  a_strobe_gate: assert property (o_fifo_strobe_gated |-> o_fifo_chip_selected) else $error("strobe unselected");
  cover property (o_packet_commit);
  cover property (fl ##1 o_pin_a7_oe);
  cover property (o_fifo_strobe_gated);
endmodule
bind port_pin_function_mux port_pin_mux_monitor mon (.*);

// >>> verification/pin_partner.sv
// far side model: fifo master or flash sharing the pins
`timescale 1ns/1ps
module pin_partner
(
  input wire i_mclk,
  input wire [17:0] i_drv,
  input wire [17:0] i_en,
  input wire [17:0] i_dut,
  input wire [17:0] i_dut_oe,
  output wire [17:0] o_wire
);
  reg t = 1'b0;
  // released lines alternate each cycle
  always @(posedge i_mclk)
    t <= ~t;
  assign o_wire = i_en & i_drv | i_dut_oe & i_dut | ~(i_en | i_dut_oe) & {18{t}};
endmodule

// >>> verification/port_pin_function_mux_test.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module port_pin_function_mux_test;
  logic i_mclk, i_sys_rst, i_endpoint_wordwide, i_nand_mode, i_fifo_strobe_req, pf, g, live;
  logic [1:0] i_interface_config_field;
  logic [7:0] i_port_a_config_reg, i_fifo_pin_polarity_reg, v, k;
  logic [7:2] i_nand_ce_as_gpio;
  logic [17:0] drv, en;
  logic [48:0] rows [8];
  int n_errors, check_count, cyc;
  // port direction registers read zero until released after reset
  wire [7:0] i_port_b_out = v, i_port_b_oe = (v ^ 8'h3c) & {8{live}}, i_port_d_out = v ^ 8'h0f;
  wire [7:0] i_port_d_oe = v & {8{live}};
  wire [7:0] i_nand_data_out = v ^ 8'hf0, i_nand_chip_enable_n = ~v;
  wire [15:0] i_fifo_data_bus_out = {v, ~v};
  wire i_port_a_bit6_out = v[0], i_port_a_bit6_oe = v[1] & live, i_port_a_bit7_out = v[2];
  wire i_port_a_bit7_oe = v[3] & live;
  wire i_fifo_status_flag_four = v[4], i_fifo_data_bus_oe = v[5], i_nand_data_oe = v[6];
  wire i_pin_a6, i_pin_a7, o_pin_a6, o_pin_a6_oe, o_pin_a7, o_pin_a7_oe, o_port_a_bit6_in, o_port_a_bit7_in;
  wire o_packet_commit, o_fifo_strobe_gated, o_fifo_chip_selected;
  wire [7:0] i_pin_b, i_pin_d, o_pin_b, o_pin_b_oe, o_pin_d, o_pin_d_oe, o_port_b_in, o_port_d_in, o_nand_data_in;
  wire [15:0] o_fifo_data_bus_in;
  wire [17:0] oe_seen = {o_pin_a6_oe, o_pin_a7_oe, o_pin_b_oe, o_pin_d_oe};
  wire [34:0] pins_seen = {o_pin_b_oe, o_pin_b & o_pin_b_oe, o_pin_d_oe, o_pin_d & o_pin_d_oe, oe_seen[17:16],
    o_pin_a7 & o_pin_a7_oe};
  wire [42:0] ins_seen = {o_pin_a6, o_port_a_bit6_in, o_port_a_bit7_in, o_port_b_in, o_port_d_in, o_nand_data_in,
    o_fifo_data_bus_in};
  port_pin_function_mux DUT (.*);
  pin_partner far (.i_mclk, .i_drv(drv), .i_en(en), .i_dut({o_pin_a6, o_pin_a7, o_pin_b, o_pin_d}),
    .i_dut_oe(oe_seen), .o_wire({i_pin_a6, i_pin_a7, i_pin_b, i_pin_d}));
  task automatic chk(input [63:0] got, input [63:0] exp);
    check_count++;
    n_errors += (got !== exp);
    if (got !== exp)
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
    if (++cyc == 400)
    begin
      n_errors++;
      end_sim;
    end
  initial
  begin
    i_sys_rst = 1'b1;
    {v, drv, en, i_fifo_strobe_req, pf, g, live, i_endpoint_wordwide, i_nand_mode, i_interface_config_field} = '0;
    {i_port_a_config_reg, i_nand_ce_as_gpio, i_fifo_pin_polarity_reg} = {8'h00, 6'h00, 8'h20};
    // {cfg, word, nand, flag, gpio}, core pattern, expected pins
    rows = '{{6'b000000, 8'h5a, 8'h66, 8'h42, 8'h5a, 8'h50, 3'h6}, {6'b010000, 8'ha5, 8'h99, 8'h81, 8'ha5, 8'ha0, 3'h0},
      {6'b100000, 8'h3c, 8'hff, 8'hc3, 8'h3c, 8'h30, 3'h3}, {6'b101000, 8'h3c, 8'hff, 8'hc3, 8'hff, 8'h3c, 3'h3},
      {6'b111000, 8'he7, 8'hff, 8'h18, 8'hff, 8'he7, 3'h0}, {6'b110010, 8'h5a, 8'h00, 8'h00, 8'h5a, 8'h50, 3'h3},
      {6'b000100, 8'h4b, 8'hff, 8'hbb, 8'hff, 8'hb4, 3'h6}, {6'b110101, 8'h4b, 8'hff, 8'hbb, 8'h4b, 8'h40, 3'h6}};
    repeat (3) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    @(negedge i_mclk);
    chk(oe_seen, 18'h00000);
    live = 1'b1;
    foreach (rows[i])
    begin
      {i_interface_config_field, i_endpoint_wordwide, i_nand_mode, pf, g, v} = rows[i][48:35];
      {i_port_a_config_reg, i_nand_ce_as_gpio} = {pf, 7'h00, {6{g}}};
      repeat (3) @(negedge i_mclk);
      chk(pins_seen, rows[i][34:0]);
      $display("row %0d done", i);
    end
    // far side drives every pin; synchronised values reach the core side
    {i_interface_config_field, i_endpoint_wordwide, i_nand_mode, i_port_a_config_reg} = {2'h3, 2'h2, 8'h00};
    {v, en, drv} = {8'h01, 18'h3ffff, 18'h26996};
    repeat (8) @(negedge i_mclk);
    chk(ins_seen, {3'h6, 8'h69, 8'h96, 8'h69, 16'h9669});
    {i_endpoint_wordwide, v, drv[15:8]} = {1'b0, 8'h00, 8'ha5};
    repeat (8) @(negedge i_mclk);
    chk({o_port_b_in, o_fifo_data_bus_in}, {8'ha5, 16'h00a5});
    $display("input test done");
    {i_interface_config_field, i_endpoint_wordwide, i_nand_mode, i_port_a_config_reg} = {2'h3, 2'h2, 8'h00};
    {v, i_fifo_strobe_req, en} = {8'he7, 1'b1, 18'h30000};
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 2; c++)
      begin
        i_fifo_pin_polarity_reg = {2'h0, p[0], 5'h00};
        drv = {~p[0], c[0], 16'h0000};
        repeat (8) @(negedge i_mclk);
        chk({o_fifo_strobe_gated, o_fifo_chip_selected}, {2{~c[0]}});
        drv[17] = p[0];
        repeat (8) @(negedge i_mclk) k = {k[6:0], o_packet_commit};
        chk(k, c ? 8'h00 : 8'h08);
        $display("commit test %0d %0d done", p, c);
      end
    // flag mode left selected: the reset interface field must keep bit 7 an input
    {live, i_port_a_config_reg} = {1'b0, 8'h80};
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    @(negedge i_mclk);
    chk(oe_seen, 18'h00000);
    $display("reset test done");
    end_sim;
  end
endmodule
